// [hw/irq_edge_priority_map.svh]
`ifndef IRQ_EDGE_PRIORITY_MAP_SVH
`define IRQ_EDGE_PRIORITY_MAP_SVH

`define EPC_CTRL_OFFSET       4'h0
`define EPC_GATE_OFFSET       4'h4
`define EPC_FLAG_OFFSET       4'h8
`define EPC_MASK_OFFSET       4'hc
`define EPC_CTRL_RESET        8'hf5
`define EPC_CTRL_WMASK        8'hf5
`define EPC_PULLUP_BIT        7
`define EPC_EDGE_A_BIT        6
`define EPC_EDGE_B_BIT        5
`define EPC_EDGE_C_BIT        4
`define EPC_TMR_PRIO_BIT      2
`define EPC_PORTB_PRIO_BIT    0
`define EPC_GATE_PRIO_ON_BIT  0
`define EPC_GATE_HIGH_BIT     1
`define EPC_GATE_LOW_BIT      2
`define EPC_GATE_WMASK        8'h07
`define EPC_FLAG_WIDTH        5

`endif

// [hw/irq_edge_priority_pkg.sv]
package irq_edge_priority_pkg;
	typedef enum logic [1:0]
	{
		BUS_IDLE,
		BUS_DONE
	} bus_state_t;
	typedef logic [7:0] reg_byte_t;
endpackage

// [hw/edge_detect.sv]
`timescale 1ns/1ps
module edge_detect
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic pinIn,
	input  wire logic risingSel,
	output logic      edgeSeen
);
	logic syncA;
	logic syncB;
	logic prevLevel;

	// Two stages against metastability, third holds the previous level
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			syncA     <= 1'b0;
			syncB     <= 1'b0;
			prevLevel <= 1'b0;
		end
		else
		begin
			syncA     <= pinIn;
			syncB     <= syncA;
			prevLevel <= syncB;
		end
	end

	wire rise = syncB & ~prevLevel;
	wire fall = ~syncB & prevLevel;
	assign edgeSeen = risingSel ? rise : fall; // [RQ3] [RQ4]
endmodule

// [hw/irq_edge_priority_config.sv]
// What this block does
// RQ1: Bit 5 selects edge of second input
// RQ2: Bit 4 selects edge of third input
// RQ3: One means rising edge, bit 6 included
// RQ4: Zero means falling edge detected instead
// RQ5: Priority bits 2,0 route high/low; 3,1 zero
// RQ6: With priorities, two gates split high/low
// RQ7: Flags set regardless of any enable
`timescale 1ns/1ps
`include "irq_edge_priority_map.svh"
module irq_edge_priority_config
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        ext_irq_a_pin,
	input  wire logic        ext_irq_b_pin,
	input  wire logic        ext_irq_c_pin,
	input  wire logic        timerOverflow,
	input  wire logic        portBChange,
	output logic             port_b_pullup_disable_n,
	output logic [2:0]       extEdgeSelect,
	output logic             timer_zero_overflow_priority,
	output logic             port_b_change_priority,
	output logic             highIrq,
	output logic             lowIrq,
	output logic             irq
);
	irq_edge_priority_pkg::reg_byte_t ctrl;
	irq_edge_priority_pkg::reg_byte_t gate;
	logic [`EPC_FLAG_WIDTH-1:0] flags;
	logic [`EPC_FLAG_WIDTH-1:0] mask;
	irq_edge_priority_pkg::bus_state_t busState;
	logic [2:0] extEdge;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wmask);
		merge = (old & ~wmask) | (writedata[7:0] & wmask);
	endfunction

	// One decoder shared by write strobes and read select
	function automatic logic regHit(input logic [3:0] addr, input logic [3:0] offset);
		regHit = (addr == offset);
	endfunction

	wire ext_irq_a_edge_select = ctrl[`EPC_EDGE_A_BIT];
	wire ext_irq_b_edge_select = ctrl[`EPC_EDGE_B_BIT]; // [RQ1]
	wire ext_irq_c_edge_select = ctrl[`EPC_EDGE_C_BIT]; // [RQ2]
	wire priority_levels_on    = gate[`EPC_GATE_PRIO_ON_BIT];
	wire global_high_irq_gate  = gate[`EPC_GATE_HIGH_BIT];
	wire global_low_irq_gate   = gate[`EPC_GATE_LOW_BIT];

	// Pins are asynchronous, each detector synchronises its own
	edge_detect edgeA
	(
		.ref_clk   (ref_clk),
		.rst       (rst),
		.pinIn     (ext_irq_a_pin),
		.risingSel (ext_irq_a_edge_select), // [RQ3]
		.edgeSeen  (extEdge[0])
	);
	edge_detect edgeB
	(
		.ref_clk   (ref_clk),
		.rst       (rst),
		.pinIn     (ext_irq_b_pin),
		.risingSel (ext_irq_b_edge_select), // [RQ1]
		.edgeSeen  (extEdge[1])
	);
	edge_detect edgeC
	(
		.ref_clk   (ref_clk),
		.rst       (rst),
		.pinIn     (ext_irq_c_pin),
		.risingSel (ext_irq_c_edge_select), // [RQ2]
		.edgeSeen  (extEdge[2])
	);

	// Flag order: a, b, c, timer, port B
	wire [`EPC_FLAG_WIDTH-1:0] events = {portBChange, timerOverflow, extEdge};
	// Timer and port B events already live on this clock
	wire busTake   = (read | write) & (busState == irq_edge_priority_pkg::BUS_IDLE);
	wire busDone   = (busState == irq_edge_priority_pkg::BUS_DONE);
	wire readTake  = busTake & read;
	// Writes land only on the edge where waitrequest is low
	wire wrTake    = busDone & write & byteenable[0];
	wire ctrlSel   = regHit(address, `EPC_CTRL_OFFSET);
	wire gateSel   = regHit(address, `EPC_GATE_OFFSET);
	wire flagSel   = regHit(address, `EPC_FLAG_OFFSET);
	wire maskSel   = regHit(address, `EPC_MASK_OFFSET);
	wire ctrlWr    = wrTake & ctrlSel;
	wire gateWr    = wrTake & gateSel;
	wire flagWr    = wrTake & flagSel;
	wire maskWr    = wrTake & maskSel;

	// Only the ones written clear, zeros leave flags alone
	wire [`EPC_FLAG_WIDTH-1:0] flagClr = flagWr ? writedata[`EPC_FLAG_WIDTH-1:0] : '0;
	wire [`EPC_FLAG_WIDTH-1:0] keptFlags = flags & ~flagClr;
	// Set beats clear so no event is lost
	wire [`EPC_FLAG_WIDTH-1:0] next_flags = keptFlags | events; // [RQ7]

	// Unimplemented bits read as zero
	wire [7:0] ctrlRead = ctrl;
	wire [7:0] gateRead = gate;
	wire [7:0] flagRead = {3'h0, flags};
	wire [7:0] maskRead = {3'h0, mask};
	wire [7:0] readMux =
		ctrlSel ? ctrlRead :
		gateSel ? gateRead :
		flagSel ? flagRead :
		maskSel ? maskRead : 8'h00;

	// Routing: pin edges always high, timer and port B high when priority bit set, or everything high without levels
	wire [`EPC_FLAG_WIDTH-1:0] prioHigh =
		{port_b_change_priority, timer_zero_overflow_priority, 3'h7}; // [RQ5]
	wire [`EPC_FLAG_WIDTH-1:0] pend = flags & mask;
	wire [`EPC_FLAG_WIDTH-1:0] highRoute = priority_levels_on ? prioHigh : '1;
	wire [`EPC_FLAG_WIDTH-1:0] lowRoute  = priority_levels_on ? ~prioHigh : '0;
	wire anyHigh = |(pend & highRoute);
	wire anyLow  = |(pend & lowRoute);
	// Without levels the low gate is ignored
	wire next_highIrq = anyHigh & global_high_irq_gate; // [RQ6]
	// High gate off blocks low requests too
	wire next_lowIrq  = anyLow & global_high_irq_gate & global_low_irq_gate; // [RQ6]

	wire [7:0] next_ctrl = ctrlWr ? merge(ctrl, `EPC_CTRL_WMASK) : ctrl; // [RQ5]
	wire [7:0] next_gate = gateWr ? merge(gate, `EPC_GATE_WMASK) : gate;
	wire [`EPC_FLAG_WIDTH-1:0] next_mask = maskWr ? writedata[`EPC_FLAG_WIDTH-1:0] : mask;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ctrl <= `EPC_CTRL_RESET;
		else
			ctrl <= next_ctrl; // [RQ5]
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			gate <= 8'h00;
		else
			gate <= next_gate;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			mask <= '0;
		else
			mask <= next_mask;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			flags <= '0;
		else
			flags <= next_flags; // [RQ7]
	end

	// One wait cycle keeps read data registered
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			busState <= irq_edge_priority_pkg::BUS_IDLE;
		else
		begin
			case (busState)
				irq_edge_priority_pkg::BUS_IDLE:
				begin
					if (read | write)
						busState <= irq_edge_priority_pkg::BUS_DONE;
				end
				irq_edge_priority_pkg::BUS_DONE:
				begin
					busState <= irq_edge_priority_pkg::BUS_IDLE;
				end
				default:
				begin
					busState <= irq_edge_priority_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// Read data stands through the cycle in which waitrequest is low
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			readdata <= 32'h00000000;
		else if (readTake)
			readdata <= {24'h000000, readMux};
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			highIrq <= 1'b0;
		else
			highIrq <= next_highIrq; // [RQ6]
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			lowIrq <= 1'b0;
		else
			lowIrq <= next_lowIrq; // [RQ6]
	end

	// Every access costs exactly one wait state
	assign waitrequest                  = (read | write) & ~busDone;
	assign port_b_pullup_disable_n      = ctrl[`EPC_PULLUP_BIT];
	assign extEdgeSelect                = {ext_irq_c_edge_select, ext_irq_b_edge_select,
		ext_irq_a_edge_select};
	assign timer_zero_overflow_priority = ctrl[`EPC_TMR_PRIO_BIT];
	assign port_b_change_priority       = ctrl[`EPC_PORTB_PRIO_BIT];
	assign irq                          = |pend;
endmodule

// [dv/irq_edge_priority_config_sva.sv]
`timescale 1ns/1ps
module irq_edge_priority_config_sva
(
	input logic			ref_clk,
	input logic			rst,
	input logic [3:0]	address,
	input logic			write,
	input logic [31:0]	writedata,
	input logic			waitrequest,
	input logic			ext_irq_a_pin,
	input logic			timerOverflow,
	input logic [2:0]	extEdgeSelect,
	input logic			timer_zero_overflow_priority,
	input logic			lowIrq,
	input logic			irq
);
	logic [4:0]	mask;
	logic [2:0]	gate;
	wire		done = write && !waitrequest;
	wire		ctrlWr = done && address == 4'h0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Shadows, since mask and gate state does not reach the ports
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			{mask, gate} <= 8'h00;
		else if (done && address == 4'hc)
			mask <= writedata[4:0];
		else if (done && address == 4'h4)
			gate <= writedata[2:0];
	a_edge_b_map:
		assert property (ctrlWr |=> extEdgeSelect[1] == $past(writedata[5])) else $error("edge b");
	a_edge_c_map:
		assert property (ctrlWr |=> extEdgeSelect[2] == $past(writedata[4])) else $error("edge c");
	a_rise_detect:
		assert property ($rose(ext_irq_a_pin) && extEdgeSelect[0] && mask[0] && !write
			|-> ##[1:5] irq) else $error("rise missed");
	a_fall_detect:
		assert property ($fell(ext_irq_a_pin) && !extEdgeSelect[0] && mask[0] && !write
			|-> ##[1:5] irq) else $error("fall missed");
	a_prio_map:
		assert property (ctrlWr |=> timer_zero_overflow_priority == $past(writedata[2]))
			else $error("prio");
	a_low_gate:
		assert property (lowIrq |-> $past(gate[2]) && $past(gate[0])) else $error("low gate");
	a_flag_poll:
		assert property (timerOverflow && mask[3] && !write |-> ##[1:3] irq) else $error("flag");
endmodule
bind irq_edge_priority_config irq_edge_priority_config_sva chk_u (.ref_clk, .rst, .address,
	.write, .writedata, .waitrequest, .ext_irq_a_pin, .timerOverflow, .extEdgeSelect,
	.timer_zero_overflow_priority, .lowIrq, .irq);

// [dv/ext_pin_source.sv]
`timescale 1ns/1ps
module ext_pin_source
(
	input logic			ref_clk,
	input logic			slow,
	input logic [2:0]	target,
	output logic [2:0]	pins
);
	logic [2:0]	stage;
	// Slow mode adds a cycle of board delay
	always_ff @(posedge ref_clk)
	begin
		stage <= target;
		pins <= slow ? stage : target;
	end
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
	$display("CHECK FAILED %0t mismatch", $time); end end
module tb;
	logic			ref_clk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0, slow = 1'h0, tmr = 1'h0;
	logic [3:0]		address = 4'h0;
	logic [31:0]	writedata = 32'h0, readdata, rd, v, seed = 32'h40;
	logic [2:0]		target = 3'h0, pins, edges;
	logic			waitrequest, highIrq, lowIrq, irq, tp, pu, pp, pb = 1'h0;
	int				miscompares = 0, n_compared = 0, cyc = 0, i;
	irq_edge_priority_config dut_u (.ref_clk, .rst, .address, .read, .write, .writedata,
		.byteenable(4'hf), .readdata, .waitrequest, .ext_irq_a_pin(pins[0]),
		.ext_irq_b_pin(pins[1]), .ext_irq_c_pin(pins[2]), .timerOverflow(tmr),
		.portBChange(pb), .port_b_pullup_disable_n(pu), .extEdgeSelect(edges),
		.timer_zero_overflow_priority(tp), .port_b_change_priority(pp), .highIrq, .lowIrq, .irq);
	ext_pin_source pin_u (.ref_clk, .slow, .target, .pins);
	initial forever #2.5 ref_clk = ~ref_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] ctrl_of(logic [7:0] x);
		return x & 8'hf5;
	endfunction
	task automatic settle();
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do @(posedge ref_clk); while (waitrequest);
		rd = readdata;
		write <= 1'h0;
		read <= 1'h0;
	endtask
	always @(posedge ref_clk)
		if (++cyc == 20000)
		begin
			miscompares++;
			print_verdict();
		end
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'h0;
		bus(1'h0, 4'h0, 32'h0);
		`CHK(rd, 32'hf5)
		bus(1'h0, 4'h6, 32'h0);
		`CHK(rd, 32'h0)
		repeat (6)
		begin
			v = rnd();
			bus(1'h1, 4'h0, v);
			bus(1'h0, 4'h0, 32'h0);
			`CHK(rd, {24'h0, ctrl_of(v[7:0])})
			`CHK({edges, tp, pu, pp}, {v[4], v[5], v[6], v[2], v[7], v[0]})
		end
		bus(1'h1, 4'hc, 32'h1f);
		for (i = 0; i < 6; i++)
		begin
			slow <= i[0];
			target[i % 3] <= i > 2;
			bus(1'h1, 4'h0, i > 2 ? 32'hf5 : 32'h85);
			settle();
			bus(1'h1, 4'h8, 32'h1f);
			target[i % 3] <= i < 3;
			settle();
			bus(1'h0, 4'h8, 32'h0);
			`CHK(rd, 32'h0)
			target[i % 3] <= i > 2;
			settle();
			bus(1'h0, 4'h8, 32'h0);
			`CHK({rd, irq}, {32'h1 << (i % 3), 1'h1})
		end
		bus(1'h1, 4'h0, 32'hf1);
		bus(1'h1, 4'h4, 32'h7);
		bus(1'h1, 4'h8, 32'h1f);
		tmr <= 1'h1;
		pb <= 1'h1;
		@(posedge ref_clk);
		tmr <= 1'h0;
		pb <= 1'h0;
		settle();
		`CHK({highIrq, lowIrq}, 2'h3)
		bus(1'h1, 4'h4, 32'h3);
		settle();
		`CHK({highIrq, lowIrq}, 2'h2)
		bus(1'h1, 4'hc, 32'h0);
		settle();
		`CHK({irq, highIrq, lowIrq}, 3'h0)
		print_verdict();
	end
endmodule
